// ---- core/bsfs_regs.svh ----
// Purpose: Register offsets, reset values and timing constants of the start-up sequencer.
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register.
// Notes: Definitions only.
`ifndef BSFS_REGS_SVH
`define BSFS_REGS_SVH

// ==========================================================================
// Register byte offsets
`define BSFS_OFF_CTRL 8'h00
`define BSFS_OFF_TON_DELAY 8'h04
`define BSFS_OFF_TON_RISE 8'h08
`define BSFS_OFF_FREQ 8'h0C
`define BSFS_OFF_VIN_ON 8'h10
`define BSFS_OFF_VIN_OFF 8'h14
`define BSFS_OFF_STATUS 8'h18

// ==========================================================================
// Field positions
`define BSFS_CTRL_OP_ON 0
`define BSFS_CTRL_OP_GATE 1

// ==========================================================================
// Reset values and fixed ramp constants
`define BSFS_RST_FREQ_KHZ 11'h25F
`define BSFS_RST_VIN_MV 16'h03E8
`define BSFS_RST_RISE_MS 7'h01
`define BSFS_ANALOG_RISE_MS 7'h02
`define BSFS_REF_FULL 16'h8000
`define BSFS_RST_PERIOD 12'h0CE

// ==========================================================================
// Timing
`define BSFS_CLK_NS 8
`define BSFS_CLK_KHZ 17'h1E848
`define BSFS_MS_NS 1000000
`define BSFS_FREQ_FLOOR_KHZ 11'h020
`define BSFS_LS_STEPS 4'h8
`define BSFS_LS_HOLD 4'hF
`define BSFS_EXT_TIMEOUT 12'hFFF

`endif

// ---- core/bsfs_pkg.sv ----
// Purpose: Types of the start-up and frequency sequencer.
// Assumes: Constants live in bsfs_regs.svh.
// Notes: All state of the core is one packed struct.
package bsfs_pkg;

    typedef enum logic [1:0] {
        SEQ_OFF = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_RISE = 2'b10,
        SEQ_ON = 2'b11
    } bsfs_seq_t;

    typedef struct packed {
        logic op_on;
        logic op_gate;
        logic [6:0] ton_delay;
        logic [6:0] ton_rise;
        logic [10:0] freq_khz;
        logic [15:0] vin_on;
        logic [15:0] vin_off;
    } bsfs_cfg_t;

    typedef struct packed {
        logic hreadyout;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] wr_addr;
        bsfs_cfg_t cfg;
        logic [1:0] en_sy;
        logic [1:0] ext_sy;
        logic [1:0] ocp_sy;
        logic [1:0] ovp_sy;
        logic [1:0] von_sy;
        logic [1:0] voff_sy;
        logic ext_prev;
        logic init_prev;
        logic init_seen;
        logic analog;
        logic [3:0] rt_code;
        logic ext_at_init;
        logic sync_fault;
        logic vin_ok;
        bsfs_seq_t seq;
        logic [23:0] timer;
        logic [24:0] ref_acc;
        logic [15:0] ref_dac;
        logic [11:0] ext_cnt;
        logic [11:0] ext_period;
        logic ext_present;
        logic [11:0] period;
        logic [11:0] sw_cnt;
        logic first_hs;
        logic [3:0] ls_level;
        logic [3:0] ls_hold;
        logic hs_gate;
        logic ls_gate;
        logic conv_en;
        logic [15:0] ramp_step;
    } bsfs_state_t;

endpackage : bsfs_pkg

// ---- core/bsfs_sequencer.sv ----
// Purpose: Enable gating, pre-bias start-up, soft-start ramp and switching-frequency control.
// Assumes: Comparator and pin inputs are asynchronous; ADC and loop inputs share hclk.
// Notes: Registers sit on AHB-Lite with zero wait states.
// Contract
// - Convert only with enable and bus voltage good.
// - UVLO defaults 1 V, on/off levels writable.
// - Input ADC reading only reported, never gating.
// - Low side off until first high-side pulse.
// - Low side starts 1/8, steps every 16.
// - Analog ramp waits for enable, bus, config.
// - Analog ramp reaches 0.5 V in 2 ms.
// - Digital ramp delay 0 to 127 ms.
// - Digital ramp time 1 to 127 ms.
// - Overcurrent and overvoltage stay active during start-up.
// - Analog frequency from sixteen resistor codes.
// - Resistor code sampled once at initialization.
// - Digital frequency defaults 607 kHz, writable.
// - Analog sync clock lost after init disables conversion.
// - Late sync clock toggles with free-running frequency; code instead slews the period to the sync clock.
// - Frequency moves gradually toward new target.
// - Ramp slope tracks period for constant amplitude.
// - Enable low turns both drivers off immediately.
// - Digital mode may allow software shutdown.
// - Floating address strap selects analog, locks registers.
`timescale 1ns/1ps
`include "bsfs_regs.svh"

module bsfs_sequencer
    import bsfs_pkg::*;
#(
    parameter int MS_CYCLES = `BSFS_MS_NS / `BSFS_CLK_NS,
    parameter logic [11:0] FREQ_STEP = 12'h001,
    parameter logic [23:0] RAMP_AMP = 24'h010000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic enable_ccm_pin,
    input wire logic vin_above_on,
    input wire logic vin_above_off,
    input wire logic [9:0] vin_adc,
    input wire logic config_loaded,
    input wire logic init_done,
    input wire logic addr_strap_floating,
    input wire logic [9:0] rt_adc,
    input wire logic freq_resistor_clock_pin,
    input wire logic ocp_trip,
    input wire logic ovp_trip,
    input wire logic [7:0] loop_duty,
    output logic high_side_switch,
    output logic low_side_switch,
    output logic conversion_enable,
    output logic [15:0] reference_ramp_dac,
    output logic [15:0] ramp_slope,
    output logic [15:0] vin_on_level,
    output logic [15:0] vin_off_level,
    output logic [11:0] switch_period,
    output logic sync_fault
);

    localparam logic [10:0] RT_KHZ [16] = '{11'h132, 11'h164, 11'h190, 11'h1BC, 11'h1F4,
        11'h226, 11'h258, 11'h2C2, 11'h2EE, 11'h320, 11'h39B, 11'h3E8, 11'h443, 11'h4B0,
        11'h535, 11'h5DC};
    localparam logic [23:0] MS_CYC = 24'(MS_CYCLES);

    bsfs_state_t s_reg;
    bsfs_state_t s_next;

    logic en_ok;
    logic ext_edge;
    logic wrap;
    logic [6:0] rise_ms;
    logic [6:0] delay_ms;
    logic [23:0] rise_total;
    logic [15:0] ramp_q;
    logic [24:0] ramp_r;
    logic [24:0] ramp_sum;
    logic [15:0] ramp_inc;
    logic [15:0] ramp_room;
    logic [10:0] div_khz;
    logic [11:0] free_period;
    logic [11:0] target;
    logic [19:0] hs_prod;
    logic [11:0] hs_width;
    logic [15:0] ls_prod;
    logic [12:0] ls_end;
    logic prot;

    // ======================================================================
    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.hreadyout = 1'b1;
        prot = s_reg.ocp_sy[1] | s_reg.ovp_sy[1];
        // Pin and comparator inputs pass two flops before use.
        s_next.en_sy = {s_reg.en_sy[0], enable_ccm_pin};
        s_next.ext_sy = {s_reg.ext_sy[0], freq_resistor_clock_pin};
        s_next.ocp_sy = {s_reg.ocp_sy[0], ocp_trip};
        s_next.ovp_sy = {s_reg.ovp_sy[0], ovp_trip};
        s_next.von_sy = {s_reg.von_sy[0], vin_above_on};
        s_next.voff_sy = {s_reg.voff_sy[0], vin_above_off};
        s_next.ext_prev = s_reg.ext_sy[1];
        ext_edge = s_reg.ext_sy[1] & ~s_reg.ext_prev;

        // ==================================================================
        // Initialization capture: strap, resistor code and sync presence once.
        s_next.init_prev = init_done;
        if (init_done && !s_reg.init_prev && !s_reg.init_seen) begin
            s_next.init_seen = 1'b1;
            s_next.analog = addr_strap_floating;
            s_next.rt_code = rt_adc[9:6];
            s_next.ext_at_init = s_reg.ext_present;
        end

        // ==================================================================
        // Register bus. Analog mode ignores writes so the loaded set stays fixed.
        if (s_reg.wr_pend && !s_reg.analog) begin
            unique case (s_reg.wr_addr)
                `BSFS_OFF_CTRL: begin
                    s_next.cfg.op_on = hwdata[`BSFS_CTRL_OP_ON];
                    s_next.cfg.op_gate = hwdata[`BSFS_CTRL_OP_GATE];
                end
                `BSFS_OFF_TON_DELAY: s_next.cfg.ton_delay = hwdata[6:0];
                `BSFS_OFF_TON_RISE: s_next.cfg.ton_rise = hwdata[6:0];
                `BSFS_OFF_FREQ: s_next.cfg.freq_khz = hwdata[10:0];
                `BSFS_OFF_VIN_ON: s_next.cfg.vin_on = hwdata[15:0];
                `BSFS_OFF_VIN_OFF: s_next.cfg.vin_off = hwdata[15:0];
                default: begin
                end
            endcase
        end
        s_next.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            s_next.wr_pend = hwrite;
            s_next.wr_addr = {haddr[7:2], 2'b00};
            s_next.hrdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case ({haddr[7:2], 2'b00})
                    `BSFS_OFF_CTRL: s_next.hrdata = {30'h0, s_reg.cfg.op_gate, s_reg.cfg.op_on};
                    `BSFS_OFF_TON_DELAY: s_next.hrdata = {25'h0, s_reg.cfg.ton_delay};
                    `BSFS_OFF_TON_RISE: s_next.hrdata = {25'h0, s_reg.cfg.ton_rise};
                    `BSFS_OFF_FREQ: s_next.hrdata = {21'h0, s_reg.cfg.freq_khz};
                    `BSFS_OFF_VIN_ON: s_next.hrdata = {16'h0, s_reg.cfg.vin_on};
                    `BSFS_OFF_VIN_OFF: s_next.hrdata = {16'h0, s_reg.cfg.vin_off};
                    `BSFS_OFF_STATUS: s_next.hrdata = {14'h0, s_reg.sync_fault,
                        s_reg.ext_present, s_reg.analog, s_reg.vin_ok, s_reg.seq,
                        s_reg.conv_en, s_reg.first_hs, vin_adc};
                    default: s_next.hrdata = 32'h0000_0000;
                endcase
            end
        end

        // ==================================================================
        // Bus UVLO with hysteresis from the two comparators, never from the ADC.
        if (s_reg.von_sy[1]) begin
            s_next.vin_ok = 1'b1;
        end else if (!s_reg.voff_sy[1]) begin
            s_next.vin_ok = 1'b0;
        end

        // ==================================================================
        // Sync clock: measure period between rising edges, time out on loss.
        if (ext_edge) begin
            s_next.ext_cnt = 12'h000;
            // The first edge after a silence only starts the count; its span is no period.
            if (s_reg.ext_cnt != `BSFS_EXT_TIMEOUT) begin
                s_next.ext_period = s_reg.ext_cnt + 12'h001;
                s_next.ext_present = 1'b1;
            end
        end else if (s_reg.ext_cnt == `BSFS_EXT_TIMEOUT) begin
            s_next.ext_present = 1'b0;
        end else begin
            s_next.ext_cnt = s_reg.ext_cnt + 12'h001;
        end
        if (s_reg.analog && s_reg.ext_at_init && s_reg.ext_present && !s_next.ext_present) begin
            s_next.sync_fault = 1'b1;
        end

        // ==================================================================
        // Enable: pin, bus UVLO, loaded config, optional software off.
        en_ok = s_reg.en_sy[1] & s_reg.vin_ok & config_loaded & s_reg.init_seen
            & ~s_reg.sync_fault;
        if (!s_reg.analog && s_reg.cfg.op_gate && !s_reg.cfg.op_on) begin
            en_ok = 1'b0;
        end
        s_next.conv_en = en_ok;

        // ==================================================================
        // Soft-start sequence with a DDA so the reference rises linearly.
        delay_ms = s_reg.analog ? 7'h00 : s_reg.cfg.ton_delay;
        rise_ms = s_reg.analog ? `BSFS_ANALOG_RISE_MS : s_reg.cfg.ton_rise;
        if (rise_ms == 7'h00) begin
            rise_ms = `BSFS_RST_RISE_MS;
        end
        rise_total = 24'(rise_ms * MS_CYC);
        // Whole codes per cycle plus a remainder keep the ramp linear at any clock rate.
        ramp_q = 16'(`BSFS_REF_FULL / rise_total);
        ramp_r = 25'(`BSFS_REF_FULL % rise_total);
        ramp_sum = s_reg.ref_acc + ramp_r;
        if (ramp_sum >= {1'b0, rise_total}) begin
            ramp_sum = ramp_sum - {1'b0, rise_total};
            ramp_inc = ramp_q + 16'h0001;
        end else begin
            ramp_inc = ramp_q;
        end
        ramp_room = `BSFS_REF_FULL - s_reg.ref_dac;
        unique case (s_reg.seq)
            SEQ_OFF: begin
                s_next.ref_dac = 16'h0000;
                s_next.ref_acc = 25'h0;
                s_next.timer = 24'h0;
                if (en_ok) begin
                    s_next.seq = SEQ_DELAY;
                end
            end
            SEQ_DELAY: begin
                s_next.timer = s_reg.timer + 24'h1;
                if (s_reg.timer >= 24'(delay_ms * MS_CYC)) begin
                    s_next.seq = SEQ_RISE;
                end
            end
            SEQ_RISE: begin
                s_next.ref_acc = ramp_sum;
                s_next.ref_dac = (ramp_inc >= ramp_room) ? `BSFS_REF_FULL
                    : s_reg.ref_dac + ramp_inc;
                if (s_next.ref_dac == `BSFS_REF_FULL) begin
                    s_next.seq = SEQ_ON;
                end
            end
            SEQ_ON: begin
            end
        endcase
        if (!en_ok) begin
            s_next.seq = SEQ_OFF;
            s_next.ref_dac = 16'h0000;
        end

        // ==================================================================
        // Frequency: free-running from resistor code or register, sync overrides.
        div_khz = s_reg.analog ? RT_KHZ[s_reg.rt_code] : s_reg.cfg.freq_khz;
        if (div_khz < `BSFS_FREQ_FLOOR_KHZ) begin
            div_khz = `BSFS_FREQ_FLOOR_KHZ;
        end
        free_period = 12'(`BSFS_CLK_KHZ / div_khz);
        target = s_reg.ext_present ? s_reg.ext_period : free_period;
        wrap = s_reg.sw_cnt + 12'h001 >= s_reg.period;
        s_next.sw_cnt = wrap ? 12'h000 : s_reg.sw_cnt + 12'h001;
        if (wrap) begin
            // Moving one bounded step per switching period avoids loop disturbance on sync changes.
            if (s_reg.period + FREQ_STEP < target) begin
                s_next.period = s_reg.period + FREQ_STEP;
            end else if (s_reg.period > target + FREQ_STEP) begin
                s_next.period = s_reg.period - FREQ_STEP;
            end else begin
                s_next.period = target;
            end
        end
        s_next.ramp_step = 16'(RAMP_AMP / {12'h0, s_reg.period});

        // ==================================================================
        // Gate drive with pre-bias low-side stepping.
        hs_prod = s_reg.period * loop_duty;
        hs_width = hs_prod[19:8];
        ls_prod = s_reg.period * s_reg.ls_level;
        ls_end = {1'b0, hs_width} + {1'b0, ls_prod[14:3]};
        s_next.hs_gate = s_reg.seq != SEQ_OFF && en_ok && !prot && s_reg.sw_cnt < hs_width;
        s_next.ls_gate = s_reg.seq != SEQ_OFF && en_ok && !prot && s_reg.first_hs
            && s_reg.sw_cnt >= hs_width && {1'b0, s_reg.sw_cnt} < ls_end;
        if (s_reg.hs_gate) begin
            s_next.first_hs = 1'b1;
        end
        if (wrap && s_reg.first_hs && s_reg.ls_level != `BSFS_LS_STEPS) begin
            s_next.ls_hold = s_reg.ls_hold + 4'h1;
            if (s_reg.ls_hold == `BSFS_LS_HOLD) begin
                s_next.ls_level = s_reg.ls_level + 4'h1;
            end
        end
        if (s_reg.seq == SEQ_OFF) begin
            s_next.first_hs = 1'b0;
            s_next.ls_level = 4'h1;
            s_next.ls_hold = 4'h0;
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.cfg.freq_khz <= `BSFS_RST_FREQ_KHZ;
            s_reg.cfg.vin_on <= `BSFS_RST_VIN_MV;
            s_reg.cfg.vin_off <= `BSFS_RST_VIN_MV;
            s_reg.cfg.ton_rise <= `BSFS_RST_RISE_MS;
            s_reg.ls_level <= 4'h1;
            s_reg.period <= `BSFS_RST_PERIOD;
            s_reg.ext_cnt <= `BSFS_EXT_TIMEOUT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout = s_reg.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = s_reg.hrdata;
    assign high_side_switch = s_reg.hs_gate;
    assign low_side_switch = s_reg.ls_gate;
    assign conversion_enable = s_reg.conv_en;
    assign reference_ramp_dac = s_reg.ref_dac;
    assign ramp_slope = s_reg.ramp_step;
    assign vin_on_level = s_reg.cfg.vin_on;
    assign vin_off_level = s_reg.cfg.vin_off;
    assign switch_period = s_reg.period;
    assign sync_fault = s_reg.sync_fault;

    // ======================================================================
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence en_lost_s;
        !s_reg.en_sy[1];
    endsequence

    sequence drivers_off_s;
        !high_side_switch && !low_side_switch;
    endsequence

    enable_gate_a: assert property (conversion_enable |-> $past(s_reg.en_sy[1])
        && $past(s_reg.vin_ok)) else $error("conversion enabled without enable and bus");
    shutdown_fast_a: assert property (en_lost_s |=> drivers_off_s)
        else $error("drivers still on after enable low");
    ls_first_a: assert property (low_side_switch |-> s_reg.first_hs)
        else $error("low side before first high-side pulse");
    ls_step_a: assert property ($changed(s_reg.ls_level) && s_reg.seq != SEQ_OFF
        && $past(s_reg.seq) != SEQ_OFF |-> s_reg.ls_level == $past(s_reg.ls_level) + 4'h1)
        else $error("low side step not by one eighth");
    prot_off_a: assert property (prot |=> drivers_off_s)
        else $error("drivers on during protection trip");
    ramp_wait_a: assert property (s_reg.seq == SEQ_OFF |-> reference_ramp_dac == 16'h0000)
        else $error("reference moved before start");
    ref_mono_a: assert property (s_reg.seq == SEQ_RISE && $past(s_reg.seq) == SEQ_RISE
        |-> reference_ramp_dac - $past(reference_ramp_dac) <= $past(ramp_inc))
        else $error("reference jumped during ramp");
    period_slew_a: assert property ($changed(switch_period) && $past(s_reg.ext_present)
        == s_reg.ext_present |-> switch_period - $past(switch_period) <= FREQ_STEP
        || $past(switch_period) - switch_period <= FREQ_STEP)
        else $error("period step too large");
    analog_lock_a: assert property (s_reg.analog |=> $stable(s_reg.cfg))
        else $error("config changed in analog mode");
    sync_loss_a: assert property (s_reg.sync_fault |=> !conversion_enable)
        else $error("conversion kept after sync loss");

endmodule : bsfs_sequencer

// ---- tb/bsfs_sync_source.sv ----
// Purpose: External synchronization clock source facing the sequencer.
// Assumes: The clock rate is given as a half period in ns.
// Notes: Stands low while stopped, as a real source with a pull-down would.
`timescale 1ns/1ps
module bsfs_sync_source #(
    parameter realtime HALF_NS = 480.0
) (
    input wire logic run,
    output logic sync_clk
);
    // ==========================================================================
    // Clock generation
    initial begin
        sync_clk = 1'b0;
        forever begin
            wait (run === 1'b1);
            #HALF_NS sync_clk = 1'b1;
            #HALF_NS sync_clk = 1'b0;
        end
    end
endmodule : bsfs_sync_source

// ---- tb/buck_startup_freq_sequencer_bench.sv ----
// Purpose: Self-checking bench of the start-up and frequency sequencer.
// Assumes: MS_CYCLES is shortened to 50 so a millisecond is 50 clocks.
// Notes: Bus reads note their expectation in a queue; a monitor compares.
`timescale 1ns/1ps
`include "bsfs_regs.svh"
module buck_startup_freq_sequencer_bench;
    import bsfs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, en, von, voff, cfg, init, strap;
    logic [31:0] haddr, hwdata, hrdata, exp_q[$];
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [9:0] vin_adc, rt_adc;
    logic sync_clk, sync_run, ocp, ovp, hs, ls, conv, sync_fault, rd_dp, hs_seen, ls_done, watch;
    logic [7:0] loop_duty;
    logic [15:0] ref_dac, slope, von_lvl, voff_lvl;
    logic [11:0] period, prev_period;
    int miscompares, checks_done, seed, ls_bad, ls_w, step_bad, n;
    logic [31:0] r;

    bsfs_sequencer #(.MS_CYCLES(50)) i_bsfs_sequencer (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .enable_ccm_pin(en), .vin_above_on(von), .vin_above_off(voff),
        .vin_adc(vin_adc), .config_loaded(cfg), .init_done(init), .addr_strap_floating(strap),
        .rt_adc(rt_adc), .freq_resistor_clock_pin(sync_clk), .ocp_trip(ocp), .ovp_trip(ovp),
        .loop_duty(loop_duty), .high_side_switch(hs), .low_side_switch(ls),
        .conversion_enable(conv), .reference_ramp_dac(ref_dac), .ramp_slope(slope),
        .vin_on_level(von_lvl), .vin_off_level(voff_lvl), .switch_period(period),
        .sync_fault(sync_fault));
    bsfs_sync_source #(.HALF_NS(480.0)) i_bsfs_sync_source (.run(sync_run), .sync_clk(sync_clk));

    // ==========================================================================
    // Checking and closing
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    // ==========================================================================
    // Monitors
    always @(posedge hclk) begin
        if (rd_dp && hreadyout) check("hrdata", hrdata, exp_q.pop_front());
        if (rd_dp && hreadyout) check("hresp", {31'h0, hresp}, 32'h0);
        if (hreadyout) rd_dp <= hresetn && hsel && htrans[1] && !hwrite;
        prev_period <= period;
        if (watch && (period > prev_period + 12'h001 || prev_period > period + 12'h001))
            step_bad++;
        // The width of the first low-side pulse after each enable is kept for checking.
        if (conv !== 1'b1) begin
            hs_seen = 1'b0;
            ls_w = 0;
            ls_done = 1'b0;
        end else begin
            if (hs) hs_seen = 1'b1;
            if (ls && !hs_seen) ls_bad++;
            if (ls && !ls_done) ls_w++;
            else if (ls_w != 0) ls_done = 1'b1;
        end
    end

    // ==========================================================================
    // Bus master and helpers
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : ahb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ahb(1'b0, a, 32'h00000000);
    endtask : rd

    task automatic do_reset(input logic analog);
        hresetn <= 1'b0;
        init <= 1'b0;
        strap <= analog;
        sync_run <= analog;
        rt_adc <= 10'($random(seed));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // Two sync edges must be seen before initialization marks the clock present.
        repeat (300) @(posedge hclk);
        init <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask : do_reset

    task automatic startup(input int dly, input int rise);
        n = 0;
        while (conv !== 1'b1 && n < 1000) begin @(posedge hclk); n++; end
        check("conv_on", {31'h0, conv}, 32'h1);
        n = 0;
        while (ref_dac === 16'h0000 && n < 10000) begin @(posedge hclk); n++; end
        check("ramp_delay", n >= dly - 1 && n <= dly + 3, 32'h1);
        n = 0;
        while (ref_dac !== `BSFS_REF_FULL && n < 10000) begin @(posedge hclk); n++; end
        check("ramp_time", n >= rise - 2 && n <= rise + 3, 32'h1);
    endtask : startup

    // ==========================================================================
    // Stimulus
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        repeat (80000) @(posedge hclk);
        miscompares++;
        test_done();
    end

    initial begin
        seed = 32'h4757;
        {hresetn, hsel, hwrite, en, von, voff, cfg, init, strap, sync_run, ocp, ovp} = '0;
        {haddr, hwdata, htrans, hsize, vin_adc, rt_adc, rd_dp, watch} = '0;
        {miscompares, checks_done, ls_bad, step_bad} = '0;
        loop_duty = 8'h80;
        do_reset(1'b0);
        hsel <= 1'b1;
        rd(`BSFS_OFF_FREQ, 32'h0000025F);
        rd(`BSFS_OFF_VIN_ON, 32'h000003E8);
        rd(`BSFS_OFF_VIN_OFF, 32'h000003E8);
        check("vin_off_level", {16'h0000, voff_lvl}, 32'h000003E8);
        rd(8'h1C, 32'h00000000);
        r = $random(seed);
        ahb(1'b1, `BSFS_OFF_VIN_ON, {16'h0000, r[15:0]});
        rd(`BSFS_OFF_VIN_ON, {16'h0000, r[15:0]});
        check("vin_on_level", {16'h0000, von_lvl}, {16'h0000, r[15:0]});
        ahb(1'b1, `BSFS_OFF_FREQ, 32'h000005AE);
        rd(`BSFS_OFF_FREQ, 32'h000005AE);
        ahb(1'b1, `BSFS_OFF_FREQ, 32'h0000025F);
        ahb(1'b1, `BSFS_OFF_TON_DELAY, 32'h00000002);
        ahb(1'b1, `BSFS_OFF_TON_RISE, 32'h00000002);
        // A full-scale input reading must not stand in for the bus comparator.
        en <= 1'b1;
        cfg <= 1'b1;
        vin_adc <= 10'h3FF;
        repeat (20) @(posedge hclk);
        check("conv_uvlo", {31'h0, conv}, 32'h0);
        von <= 1'b1;
        voff <= 1'b1;
        startup(100, 100);
        repeat (100) @(posedge hclk);
        check("ls_first", ls_w >= period / 8 - 2 && ls_w <= period / 8 + 2, 32'h1);
        check("ls_order", ls_bad, 32'h0);
        for (int k = 0; k < 2; k++) begin
            {ocp, ovp} <= k ? 2'b01 : 2'b10;
            repeat (4) @(posedge hclk);
            n = 0;
            repeat (16) begin @(posedge hclk); n += hs | ls; end
            check("trip_gates", n, 32'h0);
            {ocp, ovp} <= 2'b00;
            repeat (4) @(posedge hclk);
        end
        en <= 1'b0;
        repeat (4) @(posedge hclk);
        check("en_off", {30'h0, hs, ls, conv}, 32'h0);
        en <= 1'b1;
        startup(100, 100);
        ahb(1'b1, `BSFS_OFF_CTRL, 32'h00000002);
        repeat (3) @(posedge hclk);
        check("op_off", {31'h0, conv}, 32'h0);
        ahb(1'b1, `BSFS_OFF_CTRL, 32'h00000003);
        startup(100, 100);
        // A clock arriving late must pull the period over one step at a time.
        watch <= 1'b1;
        sync_run <= 1'b1;
        repeat (22000) @(posedge hclk);
        check("sync_period", period >= 12'd118 && period <= 12'd122, 32'h1);
        check("slope", slope >= 16'd545 && slope <= 16'd547, 32'h1);
        sync_run <= 1'b0;
        repeat (20000) @(posedge hclk);
        check("free_period", period >= 12'd204 && period <= 12'd206, 32'h1);
        watch <= 1'b0;
        check("step", step_bad, 32'h0);
        do_reset(1'b1);
        ahb(1'b1, `BSFS_OFF_FREQ, 32'h00000300);
        rd(`BSFS_OFF_FREQ, 32'h0000025F);
        startup(0, 100);
        sync_run <= 1'b0;
        n = 0;
        while (sync_fault !== 1'b1 && n < 5000) begin @(posedge hclk); n++; end
        repeat (2) @(posedge hclk);
        check("sync_lost", {30'h0, sync_fault, conv}, 32'h2);
        test_done();
    end
endmodule : buck_startup_freq_sequencer_bench
